//--- bmp_pkg.sv
// Purpose: Constants for the beam-mode pulse controller.
// Assumes: 40 MHz system clock, registers on an A16/D8(O) slave port.
// Notes: Register index n sits at odd byte address base + 2n + 1.
package bmp_pkg;
    typedef enum logic [1:0] {
        BMP_VL   = 2'h0,
        BMP_TUNE = 2'h1,
        BMP_CW   = 2'h2,
        BMP_USER = 2'h3
    } bmp_mode_e;

    localparam logic [3:0] IDX_ACC_GO   = 4'h0;
    localparam logic [3:0] IDX_ACC_MODE = 4'h1;
    localparam logic [3:0] IDX_HALL_LO  = 4'h2;
    localparam logic [3:0] IDX_HALL_HI  = 4'h7;
    localparam logic [3:0] IDX_HARM     = 4'h8;
    localparam logic [3:0] IDX_MOD_ADJ  = 4'h9;
    localparam logic [3:0] IDX_VL_LEN   = 4'hA;

    localparam logic [5:0] AM_SHORT_USER = 6'h29;
    localparam logic [5:0] AM_SHORT_SUP  = 6'h2D;

    localparam logic [1:0] RST_MODE    = 2'h0;
    localparam logic [3:0] RST_MOD_ADJ = 4'h8;
    localparam logic [5:0] RST_VL_LEN  = 6'h00;
    localparam logic [5:0] RST_HARM    = 6'h00;
    localparam logic [5:0] VL_LEN_MAX  = 6'h27;

    localparam int CLK_MHZ        = 40;
    localparam int VL_UNIT_NS     = 250;
    localparam int MOD_STEP_NS    = 125;
    localparam int MOD_MIN_NS     = 98500;
    localparam int TUNE_BEAM_NS   = 354000;
    localparam int MOD_START_NS   = 250000;
    localparam int VL_UNIT_CYC    = VL_UNIT_NS * CLK_MHZ / 1000;
    localparam int MOD_STEP_CYC   = MOD_STEP_NS * CLK_MHZ / 1000;
    localparam int MOD_MIN_CYC    = MOD_MIN_NS * CLK_MHZ / 1000;
    localparam int TUNE_BEAM_CYC  = TUNE_BEAM_NS * CLK_MHZ / 1000;
    localparam int MOD_START_CYC  = MOD_START_NS * CLK_MHZ / 1000;
endpackage

//--- bmp_controller.sv
// Purpose: Beam-mode gating, pulse shaping and VME registers for three halls.
// Assumes: All pin inputs are asynchronous; fault inputs are active high.
// Notes: Every output is registered; a cycle of the bus is acknowledged only on a hit.
`timescale 1ns/100ps
module bmp_controller import bmp_pkg::*; #(
    parameter int TUNE_BEAM = TUNE_BEAM_CYC,
    parameter int MOD_START = MOD_START_CYC,
    parameter logic [15:5] BASE_ADDR = 11'h000
) (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [15:1] vme_addr,
    input  wire logic [5:0]  vme_am,
    input  wire logic        vme_as_n,
    input  wire logic        vme_ds0_n,
    input  wire logic        vme_ds1_n,
    input  wire logic        vme_lword_n,
    input  wire logic        vme_write_n,
    input  wire logic [7:0]  vme_data_in,
    output logic      [7:0]  vme_data_out,
    output logic             vme_data_oe,
    output logic             vme_dtack_out,
    output logic             vme_dtack_oe,
    input  wire logic        line_sync_in,
    input  wire logic        beam_sync_in,
    input  wire logic        valve_open_in,
    input  wire logic        pulser_beam_in,
    input  wire logic        pulser_mod_in,
    input  wire logic        fast_shutdown_fault,
    input  wire logic        hall_a_shutdown_input,
    input  wire logic        hall_b_shutdown_input,
    input  wire logic        hall_c_shutdown_input,
    input  wire logic        personnel_safety_a_input,
    input  wire logic        personnel_safety_b_input,
    output logic             accel_beam,
    output logic             accel_mod,
    output logic      [2:0]  hall_beam,
    output logic      [2:0]  hall_mod,
    output logic             thermionic_beam,
    output logic             thermionic_mod
);
    localparam int SW = 45;
    typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_HOLD = 2'b01} bmp_bus_e;

    function automatic logic [1:0] mode_min(input logic [1:0] a, input logic [1:0] b);
        mode_min = (a < b) ? a : b;
    endfunction

    function automatic logic [1:0] shape(input logic [1:0] m, input logic vl, input logic tb, input logic tm);
        case (m)
            BMP_VL:   shape = {vl, 1'b0};
            BMP_TUNE: shape = {tb, tm};
            BMP_CW:   shape = 2'b10;
            default:  shape = 2'b00;
        endcase
    endfunction

    logic [1:0]    rst_sync;
    logic          rst_n;
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [SW-1:0] f;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Strobes idle high so the filtered copy does not fake a bus cycle after reset.
    assign pin_raw = {vme_as_n, vme_ds0_n, vme_ds1_n, vme_lword_n, vme_write_n, vme_am, vme_addr,
                      vme_data_in, line_sync_in, beam_sync_in, valve_open_in, pulser_beam_in,
                      pulser_mod_in, fast_shutdown_fault, hall_c_shutdown_input,
                      hall_b_shutdown_input, hall_a_shutdown_input, personnel_safety_a_input,
                      personnel_safety_b_input};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= {5'h1F, {(SW-5){1'b0}}};
            s2 <= {5'h1F, {(SW-5){1'b0}}};
            s3 <= {5'h1F, {(SW-5){1'b0}}};
        end else begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    for (genvar g = 0; g < SW; g++) begin : g_filt
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                f[g] <= (g >= SW - 5);
            end else if (s2[g] == s3[g]) begin
                f[g] <= s3[g];
            end
        end
    end

    logic        as_n, ds0_n, ds1_n, lword_n, write_n;
    logic [5:0]  am;
    logic [15:1] addr;
    logic [7:0]  wdata;
    logic        line_sync, beam_sync, valve_open, p_beam, p_mod;
    logic        fsd_acc_in, pss_a_in, pss_b_in;
    logic [2:0]  fsd_hall_in;
    assign {as_n, ds0_n, ds1_n, lword_n, write_n, am, addr, wdata, line_sync, beam_sync,
            valve_open, p_beam, p_mod, fsd_acc_in, fsd_hall_in, pss_a_in, pss_b_in} = f;

    bmp_bus_e   bus_state;
    logic       hit_q;
    logic [3:0] idx;
    logic       start, hit, wr_stb;
    logic [1:0] hall_sel;
    logic [7:0] rd_mux;

    assign idx = addr[4:1];
    assign hit = (addr[15:5] == BASE_ADDR) && (idx <= IDX_VL_LEN);
    assign start = (bus_state == BUS_IDLE) && !as_n && !ds0_n && ds1_n && lword_n
                   && ((am == AM_SHORT_USER) || (am == AM_SHORT_SUP));
    assign wr_stb = start && hit && !write_n;
    assign hall_sel = 2'(idx[2:1] - 2'd1);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state     <= BUS_IDLE;
            hit_q         <= 1'b0;
            vme_dtack_out <= 1'b1;
            vme_dtack_oe  <= 1'b0;
            vme_data_oe   <= 1'b0;
            vme_data_out  <= 8'h00;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (start) begin
                        bus_state     <= BUS_HOLD;
                        hit_q         <= hit;
                        vme_dtack_out <= 1'b0;
                        vme_dtack_oe  <= hit;
                        vme_data_oe   <= hit && write_n;
                        vme_data_out  <= rd_mux;
                    end
                end
                BUS_HOLD: begin
                    if (ds0_n || as_n) begin
                        bus_state     <= BUS_IDLE;
                        hit_q         <= 1'b0;
                        vme_dtack_out <= 1'b1;
                        vme_dtack_oe  <= 1'b0;
                        vme_data_oe   <= 1'b0;
                    end
                end
                default: begin
                    bus_state    <= BUS_IDLE;
                    vme_dtack_oe <= 1'b0;
                    vme_data_oe  <= 1'b0;
                end
            endcase
        end
    end

    logic       acc_go, test_mode, pss_a_lat, pss_b_lat, acc_fsd;
    logic [1:0] acc_mode;
    logic [2:0] hall_go, hall_fsd;
    logic [1:0] hall_mode [3];
    logic [3:0] mod_adj;
    logic [5:0] vl_len, harm;
    logic       acc_wr, acc_ok, acc_en;
    logic [2:0] hall_ok;

    assign acc_wr = wr_stb && (idx == IDX_ACC_MODE);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_go    <= 1'b0;
            acc_mode  <= RST_MODE;
            test_mode <= 1'b0;
            mod_adj   <= RST_MOD_ADJ;
            vl_len    <= RST_VL_LEN;
            harm      <= RST_HARM;
        end else if (wr_stb) begin
            case (idx)
                IDX_ACC_GO:   acc_go <= wdata[0];
                IDX_ACC_MODE: begin
                    acc_mode  <= wdata[5:4];
                    test_mode <= wdata[3];
                end
                IDX_HARM:     harm <= wdata[5:0];
                IDX_MOD_ADJ:  mod_adj <= wdata[3:0];
                IDX_VL_LEN:   vl_len <= (wdata[5:0] > VL_LEN_MAX) ? VL_LEN_MAX : wdata[5:0];
                default:      acc_go <= acc_go;
            endcase
        end
    end

    // Hall writes are clamped at once, so the stored field is always the running mode.
    for (genvar h = 0; h < 3; h++) begin : g_hall
        logic hall_wr, hall_go_wr;
        assign hall_go_wr = wr_stb && (idx >= IDX_HALL_LO) && (idx <= IDX_HALL_HI)
                            && (hall_sel == 2'(h)) && !idx[0];
        assign hall_wr = wr_stb && (idx >= IDX_HALL_LO) && (idx <= IDX_HALL_HI)
                         && (hall_sel == 2'(h)) && idx[0];
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                hall_go[h]   <= 1'b0;
                hall_mode[h] <= RST_MODE;
                hall_fsd[h]  <= 1'b0;
            end else begin
                if (hall_go_wr) begin
                    hall_go[h] <= wdata[0];
                end
                if (hall_wr) begin
                    hall_mode[h] <= mode_min(wdata[5:4], acc_mode);
                end else if (acc_wr) begin
                    hall_mode[h] <= mode_min(hall_mode[h], wdata[5:4]);
                end
                hall_fsd[h] <= fsd_hall_in[h] || (hall_fsd[h] && !hall_wr);
            end
        end
    end

    // A fault that is still present re-sets its latch in the same cycle as the clear.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pss_a_lat <= 1'b0;
            pss_b_lat <= 1'b0;
            acc_fsd   <= 1'b0;
        end else begin
            pss_a_lat <= pss_a_in || (pss_a_lat && !acc_wr);
            pss_b_lat <= pss_b_in || (pss_b_lat && !acc_wr);
            acc_fsd   <= fsd_acc_in || (acc_fsd && !acc_wr);
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        case (idx)
            IDX_ACC_GO:   rd_mux = {7'h00, acc_go};
            IDX_ACC_MODE: rd_mux = {acc_en, beam_sync, acc_mode, test_mode, pss_a_lat, pss_b_lat,
                                    acc_fsd};
            IDX_HARM:     rd_mux = {2'h0, harm};
            IDX_MOD_ADJ:  rd_mux = {4'h0, mod_adj};
            IDX_VL_LEN:   rd_mux = {2'h0, vl_len};
            default: begin
                if (idx[0]) begin
                    rd_mux = {hall_ok[hall_sel], 1'b0, hall_mode[hall_sel], 3'h0,
                              hall_fsd[hall_sel]};
                end
            end
        endcase
    end

    logic        line_q, line_edge;
    logic [9:0]  vl_cnt;
    logic [15:0] tune_cnt;
    logic        tune_run, vl_pulse, tune_beam, tune_mod;
    logic [15:0] mod_end;

    assign line_edge = line_sync && !line_q;
    assign mod_end = 16'(MOD_START + MOD_MIN_CYC + MOD_STEP_CYC * int'(mod_adj));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_q   <= 1'b0;
            vl_cnt   <= 10'h000;
            tune_cnt <= 16'h0000;
            tune_run <= 1'b0;
        end else begin
            line_q <= line_sync;
            if (line_edge) begin
                vl_cnt <= 10'(VL_UNIT_CYC * (int'(vl_len) + 1));
            end else if (vl_cnt != 10'h000) begin
                vl_cnt <= vl_cnt - 10'h001;
            end
            if (line_edge) begin
                tune_cnt <= 16'h0000;
                tune_run <= 1'b1;
            end else if (tune_run) begin
                tune_cnt <= tune_cnt + 16'h0001;
                if (tune_cnt == 16'(TUNE_BEAM - 1)) begin
                    tune_run <= 1'b0;
                end
            end
        end
    end

    assign vl_pulse = (vl_cnt != 10'h000);
    assign tune_beam = tune_run && (tune_cnt < 16'(TUNE_BEAM));
    assign tune_mod = tune_run && (tune_cnt >= 16'(MOD_START)) && (tune_cnt < mod_end);

    logic [1:0] acc_shape;
    logic       therm_ok;

    assign acc_shape = (acc_mode == BMP_USER) ? {p_beam, p_mod}
                       : shape(acc_mode, vl_pulse, tune_beam, tune_mod);
    assign acc_en = acc_go && !pss_a_lat && !pss_b_lat && !acc_fsd;
    assign acc_ok = acc_en && (valve_open || test_mode);
    assign therm_ok = acc_go && !pss_a_lat && !pss_b_lat && !acc_fsd && (hall_fsd == 3'h0)
                      && (!valve_open || test_mode);
    assign hall_ok = {3{acc_ok}} & hall_go & ~hall_fsd;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            accel_beam      <= 1'b0;
            accel_mod       <= 1'b0;
            thermionic_beam <= 1'b0;
            thermionic_mod  <= 1'b0;
        end else begin
            {accel_beam, accel_mod} <= acc_shape & {2{acc_ok}};
            thermionic_beam <= p_beam && therm_ok;
            thermionic_mod  <= p_mod && therm_ok;
        end
    end

    for (genvar k = 0; k < 3; k++) begin : g_out
        logic [1:0] hs;
        assign hs = (hall_mode[k] == BMP_USER) ? acc_shape
                    : shape(hall_mode[k], vl_pulse, tune_beam, tune_mod);
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                hall_beam[k] <= 1'b0;
                hall_mod[k]  <= 1'b0;
            end else begin
                hall_beam[k] <= hs[1] && hall_ok[k];
                hall_mod[k]  <= hs[0] && hall_ok[k];
            end
        end
    end

    chk_rank_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hall_mode[0] <= acc_mode && hall_mode[1] <= acc_mode && hall_mode[2] <= acc_mode)
        else $error("hall mode ranks above accelerator");
    chk_go_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !acc_go |=> hall_beam == 3'h0 && hall_mod == 3'h0 && !accel_beam)
        else $error("beam present with go bit clear");
    chk_pss_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pss_a_in |=> ##1 hall_beam == 3'h0 && hall_mod == 3'h0 && !thermionic_beam)
        else $error("beam present during safety fault");
    chk_hall_fsd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fsd_hall_in[0] |=> ##1 !hall_beam[0] && !thermionic_beam)
        else $error("hall shutdown did not stop beam");
    chk_fault_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fsd_acc_in |=> acc_fsd [*2])
        else $error("accelerator shutdown latch dropped");
    chk_tune_mod: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tune_mod |-> tune_beam && tune_cnt >= 16'(MOD_START))
        else $error("modulation outside tune window");
    chk_vl_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(vl_pulse) |-> vl_cnt == 10'(VL_UNIT_CYC * (int'(vl_len) + 1)))
        else $error("viewer pulse length wrong");
    chk_bus_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (start && hit) || (bus_state == BUS_HOLD && hit_q && !ds0_n && !as_n) |=> vme_dtack_oe && !vme_dtack_out)
        else $error("bus cycle not acknowledged");
    chk_valve_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !valve_open && !test_mode |=> hall_beam == 3'h0)
        else $error("polarized beam with valve closed");
    chk_cw_hall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_mode == BMP_CW && hall_mode[0] == BMP_CW && hall_ok[0] |=> hall_beam[0])
        else $error("CW hall without beam");

    cov_tune_mod: cover property (@(posedge sys_clk) disable iff (!rst_n) hall_mod[0]);
    cov_write: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_stb);
    cov_pss: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(pss_a_lat));
    cov_pass: cover property (@(posedge sys_clk) disable iff (!rst_n)
        hall_mode[2] == BMP_USER && hall_beam[2]);
endmodule // bmp_controller

//--- bmp_pulser_model.sv
// Purpose: Pulser and gun-drive side stand-in for the controller bench.
// Assumes: Line reference is a wide high pulse every LINE_PER cycles.
// Notes: Pulser structure toggles so a Pass hall has something to follow.
`timescale 1ns/100ps
module bmp_pulser_model #(
    parameter int LINE_PER = 6000
) (
    input  wire logic sys_clk,
    input  wire logic beam_sync_on,
    output logic      line_sync_in,
    output logic      beam_sync_in,
    output logic      pulser_beam_in,
    output logic      pulser_mod_in
);
    int cnt = 0;
    always_ff @(posedge sys_clk) begin
        cnt <= (cnt == LINE_PER - 1) ? 0 : cnt + 1;
    end
    // The line pulse is wide so that the input filter cannot swallow it.
    assign line_sync_in   = (cnt < 40);
    assign beam_sync_in   = beam_sync_on;
    assign pulser_beam_in = cnt[3];
    assign pulser_mod_in  = cnt[4];
endmodule // bmp_pulser_model

//--- test_beam_mode_pulse_controller.sv
// Purpose: Self-checking bench for the beam-mode pulse controller.
// Assumes: Shortened Tune timing; the pulser model supplies the line reference.
// Notes: Stimulus moves 1 ns after the rising edge, outputs are read there too.
`timescale 1ns/100ps
module test_beam_mode_pulse_controller import bmp_pkg::*;;
    localparam int TB = 4200;
    logic        sys_clk = 0, arst_n = 0;
    logic [15:1] vme_addr = '0;
    logic [5:0]  vme_am = AM_SHORT_USER;
    logic        vme_as_n = 1, vme_ds0_n = 1, vme_ds1_n = 1, vme_lword_n = 1, vme_write_n = 1;
    logic [7:0]  vme_data_in = '0, vme_data_out, q;
    logic        vme_data_oe, vme_dtack_out, vme_dtack_oe, accel_beam, accel_mod;
    logic        line_sync_in, beam_sync_in, valve_open_in = 1, pulser_beam_in, pulser_mod_in;
    logic        fast_shutdown_fault = 0, hall_a_shutdown_input = 0, hall_b_shutdown_input = 0;
    logic        hall_c_shutdown_input = 0, personnel_safety_a_input = 0, personnel_safety_b_input = 0;
    logic        thermionic_beam, thermionic_mod;
    logic [2:0]  hall_beam, hall_mod;
    int          errors = 0, cmp_count = 0, w;
    bit          ok;
    logic        beam_sync_on = 1;

    bmp_controller #(.TUNE_BEAM(TB), .MOD_START(100)) DUT (.sys_clk, .arst_n, .vme_addr, .vme_am,
        .vme_as_n, .vme_ds0_n, .vme_ds1_n, .vme_lword_n, .vme_write_n, .vme_data_in, .vme_data_out,
        .vme_data_oe, .vme_dtack_out, .vme_dtack_oe, .line_sync_in, .beam_sync_in, .valve_open_in,
        .pulser_beam_in, .pulser_mod_in, .fast_shutdown_fault, .hall_a_shutdown_input,
        .hall_b_shutdown_input, .hall_c_shutdown_input, .personnel_safety_a_input,
        .personnel_safety_b_input, .accel_beam, .accel_mod, .hall_beam, .hall_mod,
        .thermionic_beam, .thermionic_mod);
    bmp_pulser_model PULSER (.sys_clk, .beam_sync_on, .line_sync_in, .beam_sync_in, .pulser_beam_in,
        .pulser_mod_in);

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic fail(input string m);
        errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) fail(m);
    endtask
    task automatic chkw(input int got, input int exp, input string m);
        cmp_count++;
        if (got != exp) fail(m);
    endtask
    // Strobes stay put until DTACK is seen or 40 cycles pass; the gap lets the input filter settle.
    task automatic bus(input bit wr, input logic [3:0] idx, input logic [7:0] d);
        vme_addr = {11'h000, idx};
        vme_write_n = !wr;
        vme_data_in = d;
        vme_as_n = 0;
        vme_ds0_n = 0;
        ok = 0;
        for (int n = 0; n < 40 && !ok; n++) begin
            tick();
            ok = (vme_dtack_oe === 1'b1);
        end
        q = vme_data_out;
        vme_as_n = 1;
        vme_ds0_n = 1;
        for (int n = 0; n < 40 && vme_dtack_oe !== 1'b0; n++) tick();
        repeat (6) tick();
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1, idx, d);
        if (!ok) fail("write not acknowledged");
    endtask
    task automatic rd(input logic [3:0] idx);
        bus(0, idx, 8'h00);
        if (!ok) fail("read not acknowledged");
    endtask
    task automatic width(input bit m, input int h, output int n);
        n = 0;
        for (int i = 0; i < 7000 && (m ? hall_mod[h] : hall_beam[h]) !== 1'b0; i++) tick();
        for (int i = 0; i < 7000 && (m ? hall_mod[h] : hall_beam[h]) !== 1'b1; i++) tick();
        while ((m ? hall_mod[h] : hall_beam[h]) === 1'b1 && n < 5000) begin
            tick();
            n++;
        end
    endtask

    task automatic t_reset();
        chk8({hall_beam, hall_mod, accel_beam, thermionic_beam}, 8'h00, "outputs after reset");
        rd(IDX_ACC_MODE);
        chk8(q, 8'h40, "accel status after reset");
        rd(IDX_HALL_LO);
        chk8(q, 8'h00, "hall go readback");
        vme_am = 6'h09;
        bus(0, IDX_ACC_MODE, 8'h00);
        chk8({7'h00, ok}, 8'h00, "wrong modifier acknowledged");
        vme_am = AM_SHORT_SUP;
        bus(0, 4'hB, 8'h00);
        chk8({7'h00, ok}, 8'h00, "unmapped index acknowledged");
        rd(IDX_ACC_GO);
        chk8(q, 8'h00, "go bit after reset");
        vme_am = AM_SHORT_USER;
    endtask
    task automatic t_vl();
        wr(IDX_ACC_GO, 8'h01);
        wr(IDX_ACC_MODE, 8'h00);
        wr(IDX_HALL_LO, 8'h01);
        wr(4'h4, 8'h01);
        wr(4'h3, 8'h00);
        wr(4'h5, 8'h00);
        rd(IDX_ACC_MODE);
        chk8(q, 8'hC0, "accel enabled status");
        width(0, 0, w);
        chkw(w, VL_UNIT_CYC, "default viewer pulse");
        wr(IDX_VL_LEN, 8'h3F);
        width(0, 1, w);
        chkw(w, (VL_LEN_MAX + 1) * VL_UNIT_CYC, "longest viewer pulse");
        chk8({7'h00, hall_beam[2]}, 8'h00, "idle hall C pulsed");
    endtask
    task automatic t_tune();
        wr(IDX_ACC_MODE, 8'h20);
        wr(4'h3, 8'h20);
        wr(IDX_ACC_MODE, 8'h10);
        rd(4'h3);
        chk8(q, 8'h90, "CW hall after accel tune");
        wr(4'h3, 8'h30);
        rd(4'h3);
        chk8(q, 8'h90, "hall write above accel");
        rd(4'h5);
        chk8(q, 8'h80, "viewer hall kept");
        width(0, 0, w);
        chkw(w, TB, "tune beam");
        width(1, 0, w);
        chkw(w, MOD_MIN_CYC + MOD_STEP_CYC * RST_MOD_ADJ, "tune modulation");
        wr(IDX_MOD_ADJ, 8'h0F);
        width(1, 0, w);
        chkw(w, MOD_MIN_CYC + MOD_STEP_CYC * 15, "adjusted modulation");
    endtask
    task automatic t_cw();
        wr(IDX_ACC_MODE, 8'h20);
        wr(4'h3, 8'h20);
        repeat (20) tick();
        chk8({7'h00, hall_beam[0]}, 8'h01, "CW hall beam");
        wr(IDX_HALL_LO, 8'h00);
        chk8({7'h00, hall_beam[0]}, 8'h00, "hall go off");
        wr(IDX_HALL_LO, 8'h01);
        wr(IDX_ACC_GO, 8'h00);
        chk8({5'h00, hall_beam}, 8'h00, "accel go off");
        rd(IDX_ACC_MODE);
        chk8(q, 8'h60, "status with go off");
        wr(IDX_ACC_GO, 8'h01);
    endtask
    task automatic t_hall_fault();
        chk8({7'h00, hall_beam[0]}, 8'h01, "CW hall before trip");
        hall_a_shutdown_input = 1;
        repeat (10) tick();
        chk8({7'h00, hall_beam[0]}, 8'h00, "hall trip");
        hall_a_shutdown_input = 0;
        repeat (10) tick();
        rd(4'h3);
        chk8(q, 8'h21, "hall fault latched");
        wr(4'h3, 8'h20);
        rd(4'h3);
        chk8(q, 8'hA0, "hall fault cleared");
    endtask
    // One pass each for accelerator shutdown, safety B and safety A.
    task automatic t_accel_faults();
        for (int k = 0; k < 3; k++) begin
            {personnel_safety_a_input, personnel_safety_b_input, fast_shutdown_fault} = 3'(3'b001 << k);
            repeat (10) tick();
            chk8({5'h00, hall_beam}, 8'h00, "halls run in fault");
            wr(IDX_ACC_MODE, 8'h20);
            rd(IDX_ACC_MODE);
            chk8(q, 8'h60 | (8'h01 << k), "latch while active");
            {personnel_safety_a_input, personnel_safety_b_input, fast_shutdown_fault} = 3'b000;
            repeat (10) tick();
            rd(IDX_ACC_MODE);
            chk8(q, 8'h60 | (8'h01 << k), "latch after release");
            wr(IDX_ACC_MODE, 8'h20);
            rd(IDX_ACC_MODE);
            chk8(q, 8'hE0, "latch cleared");
        end
    endtask

    // The valve picks the source; the test bit lets the inhibited source pulse as well.
    task automatic t_valve();
        valve_open_in = 0;
        repeat (10) tick();
        chk8({4'h0, hall_beam, accel_beam}, 8'h00, "polarized pulses with valve closed");
        for (int i = 0; i < 40 && thermionic_mod !== 1'b1; i++) tick();
        chk8({7'h00, thermionic_mod}, 8'h01, "thermionic blocked with valve closed");
        wr(IDX_ACC_MODE, 8'h28);
        valve_open_in = 1;
        repeat (10) tick();
        chk8({5'h00, hall_beam[0], accel_beam, accel_mod}, 8'h06, "CW with test bit");
        for (int i = 0; i < 40 && thermionic_beam !== 1'b1; i++) tick();
        chk8({7'h00, thermionic_beam}, 8'h01, "test bit did not release thermionic");
        rd(IDX_ACC_MODE);
        chk8(q, 8'hE8, "test bit readback");
        wr(IDX_ACC_MODE, 8'h20);
        chk8({6'h00, thermionic_beam, thermionic_mod}, 8'h00, "thermionic with valve open");
        beam_sync_on = 0;
        repeat (10) tick();
        rd(IDX_ACC_MODE);
        chk8(q, 8'hA0, "beam sync absent");
    endtask

    task automatic print_verdict();
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 arst_n = 1;
        repeat (4) tick();
        t_reset();
        t_vl();
        t_tune();
        t_cw();
        t_hall_fault();
        t_accel_faults();
        t_valve();
        print_verdict();
    end
    // About 35k cycles are expected; 90k cycles cuts a hang short.
    initial begin
        #2250000;
        fail("watchdog expired");
        print_verdict();
    end
endmodule // test_beam_mode_pulse_controller
